// >>> src/ats_pkg.sv
// constants, field layout and carrier types of the sequencer trigger select block
package ats_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int unsigned ATS_ADDR_W = 12;
    localparam int unsigned ATS_DATA_W = 32;
    localparam logic [11:0] ATS_TRIGSEL_OFFSET = 12'h014;
    localparam logic [11:0] ATS_STATUS_OFFSET = 12'h020;

    // ****************************************************************
    // trigger select register fields
    // ****************************************************************
    localparam int unsigned ATS_SEL_W = 4;
    localparam int unsigned ATS_SEL2_LSB = 8;
    localparam int unsigned ATS_SEL1_LSB = 4;
    localparam logic [3:0] ATS_SEL_RESET = 4'h0;

    // ****************************************************************
    // status register fields (sticky start seen, write one to clear)
    // ****************************************************************
    localparam int unsigned ATS_STAT_SEQ1_BIT = 0;
    localparam int unsigned ATS_STAT_SEQ2_BIT = 1;
    localparam logic [1:0] ATS_STAT_RESET = 2'h0;

    // ****************************************************************
    // selection codes
    // ****************************************************************
    localparam logic [3:0] ATS_SEL_PROC = 4'h0;
    localparam logic [3:0] ATS_SEL_COMP0 = 4'h1;
    localparam logic [3:0] ATS_SEL_PIN = 4'h4;
    localparam logic [3:0] ATS_SEL_TIMER = 4'h5;
    localparam logic [3:0] ATS_SEL_PWM0 = 4'h6;
    localparam logic [3:0] ATS_SEL_PWM1 = 4'h7;
    localparam logic [3:0] ATS_SEL_PWM2 = 4'h8;
    localparam logic [3:0] ATS_SEL_ALWAYS = 4'hF;

    // shared trigger producers, already in the pclk domain
    typedef struct packed {
        logic comp0;
        logic pin_edge;
        logic timer;
        logic timer_ote;
        logic [2:0] pwm;
    } ats_src_t;

endpackage

// >>> src/ats_trig_mux.sv
// one sequencer's trigger source multiplexer
`timescale 1ns/1ps
`default_nettype none

module ats_trig_mux
    import ats_pkg::*;
(
    input wire logic [3:0] sel,
    input wire logic proc_req,
    input wire ats_src_t src,
    output logic start
);

    // ****************************************************************
    // source selection
    // ****************************************************************
    // reserved codes fall to the default branch and never start sampling
    always_comb begin
        case (sel)
            ATS_SEL_PROC: start = proc_req; // see (R3)
            ATS_SEL_COMP0: start = src.comp0; // see (R3)
            ATS_SEL_PIN: start = src.pin_edge; // see (R3)
            ATS_SEL_TIMER: start = src.timer & src.timer_ote; // see (R4)
            ATS_SEL_PWM0: start = src.pwm[0]; // see (R5)
            ATS_SEL_PWM1: start = src.pwm[1]; // see (R5)
            ATS_SEL_PWM2: start = src.pwm[2]; // see (R5)
            ATS_SEL_ALWAYS: start = 1'b1; // see (R3)
            default: start = 1'b0; // see (R6)
        endcase
    end

endmodule

`default_nettype wire

// >>> src/ats_trigger_select.sv
// sequencer 2 and 1 trigger select register with apb slave and start logic
//
// Behaviour
// (R1) Sequencer 2 has a read-write 4-bit trigger select field in bits 11:8, reset to zero.
// (R2) Sequencer 1 has a read-write 4-bit trigger select field in bits 7:4, reset to zero.
// (R3) Codes map 0 processor, 1 comparator 0, 4 pin, 5 timer, 6-8 pwm 0-2, 15 always.
// (R4) The timer source starts sampling only while the timer output trigger enable is set.
// (R5) A pwm source starts sampling on the trigger that the pwm generator emits.
// (R6) Reserved codes 2, 3 and 9 to 14 never start sampling.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ats_trigger_select
    import ats_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:1] proc_sample_req,
    input wire logic comparator0_trigger,
    input wire logic external_trigger_pin,
    input wire logic timer_trigger,
    input wire logic timer_output_trigger_enable,
    input wire logic [2:0] pwm_gen_trigger,
    output logic seq2_start,
    output logic seq1_start
);

    // ****************************************************************
    // apb decode
    // ****************************************************************
    logic setup_phase;
    logic access_phase;
    logic hit_trigsel;
    logic hit_status;
    logic mapped;
    logic wr_trigsel;
    logic wr_status;

    // zero wait states: every access completes in its first access cycle
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_trigsel = (paddr == ATS_TRIGSEL_OFFSET);
    assign hit_status = (paddr == ATS_STATUS_OFFSET);
    assign mapped = hit_trigsel | hit_status;
    assign wr_trigsel = access_phase & pwrite & hit_trigsel;
    assign wr_status = access_phase & pwrite & hit_status;
    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped; // unmapped access errors

    // ****************************************************************
    // trigger select fields
    // ****************************************************************
    logic [3:0] seq2_trigger_sel_reg;
    logic [3:0] seq1_trigger_sel_reg;

    // both fields share one word, written together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq2_trigger_sel_reg <= ATS_SEL_RESET; // see (R1)
            seq1_trigger_sel_reg <= ATS_SEL_RESET; // see (R2)
        end else if (wr_trigsel) begin
            seq2_trigger_sel_reg <= pwdata[ATS_SEL2_LSB +: ATS_SEL_W]; // see (R1)
            seq1_trigger_sel_reg <= pwdata[ATS_SEL1_LSB +: ATS_SEL_W]; // see (R2)
        end
    end

    // ****************************************************************
    // external pin synchroniser and edge detect
    // ****************************************************************
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_last_reg;
    logic pin_edge;

    // the pin is asynchronous; only the second stage feeds the edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_last_reg <= 1'b0;
        end else begin
            pin_meta_reg <= external_trigger_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    // a rising pin level is one start event, not a stream of them
    assign pin_edge = pin_sync_reg & ~pin_last_reg;

    // ****************************************************************
    // source bundle and per-sequencer multiplexers
    // ****************************************************************
    ats_src_t src;
    logic seq2_start_next;
    logic seq1_start_next;

    always_comb begin
        src.comp0 = comparator0_trigger;
        src.pin_edge = pin_edge;
        src.timer = timer_trigger;
        src.timer_ote = timer_output_trigger_enable;
        src.pwm = pwm_gen_trigger;
    end

    ats_trig_mux u_mux_seq2 (
        .sel(seq2_trigger_sel_reg),
        .proc_req(proc_sample_req[2]),
        .src(src),
        .start(seq2_start_next)
    );

    ats_trig_mux u_mux_seq1 (
        .sel(seq1_trigger_sel_reg),
        .proc_req(proc_sample_req[1]),
        .src(src),
        .start(seq1_start_next)
    );

    // ****************************************************************
    // registered start outputs
    // ****************************************************************
    // one cycle of latency buys glitch-free starts for the sequencers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq2_start <= 1'b0;
            seq1_start <= 1'b0;
        end else begin
            seq2_start <= seq2_start_next; // see (R3)
            seq1_start <= seq1_start_next; // see (R3)
        end
    end

    // ****************************************************************
    // sticky start-seen status
    // ****************************************************************
    logic [1:0] start_seen_reg;
    logic [1:0] start_set;
    logic [1:0] start_clr;

    assign start_set = {seq2_start, seq1_start};
    assign start_clr = wr_status ? pwdata[1:0] : 2'h0;

    // a start in the clearing cycle wins, so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_seen_reg <= ATS_STAT_RESET;
        end else begin
            start_seen_reg <= (start_seen_reg & ~start_clr) | start_set;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [31:0] prdata_next;

    // unused and reserved bits read as zero
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_trigsel) begin
            prdata_next[ATS_SEL2_LSB +: ATS_SEL_W] = seq2_trigger_sel_reg;
            prdata_next[ATS_SEL1_LSB +: ATS_SEL_W] = seq1_trigger_sel_reg;
        end else if (hit_status) begin
            prdata_next[ATS_STAT_SEQ1_BIT] = start_seen_reg[0];
            prdata_next[ATS_STAT_SEQ2_BIT] = start_seen_reg[1];
        end
    end

    // captured in the setup cycle so the access phase sees flip-flop data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= prdata_next;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_SEL2_WRITE: assert property ( // see (R1)
        wr_trigsel |=> seq2_trigger_sel_reg == $past(pwdata[11:8])
    ) else $error("sequencer 2 select did not take the written value");

    AST_SEL1_WRITE: assert property ( // see (R2)
        wr_trigsel |=> seq1_trigger_sel_reg == $past(pwdata[7:4])
    ) else $error("sequencer 1 select did not take the written value");

    AST_SEL_READBACK: assert property ( // see (R1)
        setup_phase && !pwrite && hit_trigsel && !wr_trigsel
        |=> prdata[11:8] == seq2_trigger_sel_reg && prdata[7:4] == seq1_trigger_sel_reg
    ) else $error("trigger select read back wrong");

    AST_ALWAYS: assert property ( // see (R3)
        seq2_trigger_sel_reg == 4'hF [*2] |-> seq2_start
    ) else $error("continuous mode missed a start");

    AST_PROC: assert property ( // see (R3)
        seq1_trigger_sel_reg == 4'h0 && proc_sample_req[1] |=> seq1_start
    ) else $error("processor request did not start sequencer 1");

    AST_PIN: assert property ( // see (R3)
        $rose(pin_sync_reg) && seq2_trigger_sel_reg == 4'h4 |=> seq2_start ##1 !seq2_start
            || $past(seq2_trigger_sel_reg) != 4'h4
    ) else $error("pin edge start wrong");

    AST_TIMER_GATE: assert property ( // see (R4)
        seq1_trigger_sel_reg == 4'h5 && !timer_output_trigger_enable |=> !seq1_start
    ) else $error("timer start passed without output trigger enable");

    AST_TIMER_PASS: assert property ( // see (R4)
        seq2_trigger_sel_reg == 4'h5 && timer_output_trigger_enable && timer_trigger
        |=> seq2_start
    ) else $error("enabled timer trigger did not start sequencer 2");

    AST_PWM: assert property ( // see (R5)
        seq2_trigger_sel_reg == 4'h7 |=> seq2_start == $past(pwm_gen_trigger[1])
    ) else $error("pwm 1 start does not follow its trigger");

    AST_RESERVED: assert property ( // see (R6)
        seq1_trigger_sel_reg inside {4'h2, 4'h3, [4'h9:4'hE]} |=> !seq1_start
    ) else $error("reserved code started sequencer 1");

    AST_STICKY: assert property (
        seq2_start |=> start_seen_reg[1]
    ) else $error("sequencer 2 start not recorded");

    // the mirror checks on the other sequencer, so a crossed select or source input shows up
    AST_SEL2_HOLD: assert property ( // see (R1)
        !wr_trigsel |=> $stable(seq2_trigger_sel_reg)
    ) else $error("sequencer 2 select changed without a write");

    AST_SEL1_HOLD: assert property ( // see (R2)
        !wr_trigsel |=> $stable(seq1_trigger_sel_reg)
    ) else $error("sequencer 1 select changed without a write");

    AST_PROC2: assert property ( // see (R3)
        seq2_trigger_sel_reg == ATS_SEL_PROC |=> seq2_start == $past(proc_sample_req[2])
    ) else $error("sequencer 2 start does not follow the processor request");

    AST_COMP2: assert property ( // see (R3)
        seq2_trigger_sel_reg == ATS_SEL_COMP0 |=> seq2_start == $past(comparator0_trigger)
    ) else $error("sequencer 2 start does not follow comparator 0");

    AST_COMP1: assert property ( // see (R3)
        seq1_trigger_sel_reg == ATS_SEL_COMP0 |=> seq1_start == $past(comparator0_trigger)
    ) else $error("sequencer 1 start does not follow comparator 0");

    AST_ALWAYS1: assert property ( // see (R3)
        seq1_trigger_sel_reg == ATS_SEL_ALWAYS [*2] |-> seq1_start
    ) else $error("continuous mode missed a start on sequencer 1");

    AST_PIN1: assert property ( // see (R3)
        seq1_trigger_sel_reg == ATS_SEL_PIN |=> seq1_start == $past(pin_edge)
    ) else $error("sequencer 1 start does not follow the pin edge");

    AST_TIMER1: assert property ( // see (R4)
        seq1_trigger_sel_reg == ATS_SEL_TIMER
        |=> seq1_start == $past(timer_trigger & timer_output_trigger_enable)
    ) else $error("sequencer 1 timer start wrong");

    AST_TIMER_GATE2: assert property ( // see (R4)
        seq2_trigger_sel_reg == ATS_SEL_TIMER && !timer_output_trigger_enable |=> !seq2_start
    ) else $error("sequencer 2 timer start passed without output trigger enable");

    AST_PWM0: assert property ( // see (R5)
        seq1_trigger_sel_reg == ATS_SEL_PWM0 |=> seq1_start == $past(pwm_gen_trigger[0])
    ) else $error("pwm 0 start does not follow its trigger");

    AST_PWM1_SEQ1: assert property ( // see (R5)
        seq1_trigger_sel_reg == ATS_SEL_PWM1 |=> seq1_start == $past(pwm_gen_trigger[1])
    ) else $error("pwm 1 start on sequencer 1 does not follow its trigger");

    AST_PWM2: assert property ( // see (R5)
        seq2_trigger_sel_reg == ATS_SEL_PWM2 |=> seq2_start == $past(pwm_gen_trigger[2])
    ) else $error("pwm 2 start does not follow its trigger");

    AST_RESERVED2: assert property ( // see (R6)
        seq2_trigger_sel_reg inside {4'h2, 4'h3, [4'h9:4'hE]} |=> !seq2_start
    ) else $error("reserved code started sequencer 2");

    AST_STICKY1: assert property (
        seq1_start |=> start_seen_reg[0]
    ) else $error("sequencer 1 start not recorded");

    COV_TIMER: cover property (
        seq2_trigger_sel_reg == 4'h5 && timer_output_trigger_enable && timer_trigger
    );
    COV_PIN: cover property (seq1_trigger_sel_reg == 4'h4 && pin_edge);
    COV_CLEAR_RACE: cover property (wr_status && pwdata[1] && seq2_start);
    COV_UNMAPPED: cover property (pslverr);
    COV_PWM2: cover property (seq2_trigger_sel_reg == ATS_SEL_PWM2 && seq2_start);

endmodule

`default_nettype wire

// >>> testbench/ats_src_model.sv
// behavioural model of the on-chip trigger producers feeding the select block
`timescale 1ns/1ps
`default_nettype none

module ats_src_model
    import ats_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ats_src_t cmd,
    output logic comparator0_trigger,
    output logic external_trigger_pin,
    output logic timer_trigger,
    output logic timer_output_trigger_enable,
    output logic [2:0] pwm_gen_trigger
);
    // ****************************************************************
    // producers
    // ****************************************************************
    // each producer is a flop, so an event reaches the block one edge after the command;
    // the pin is modelled as a level and holds as long as the command does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {comparator0_trigger, external_trigger_pin, timer_trigger} <= 3'h0;
            timer_output_trigger_enable <= 1'b0;
            pwm_gen_trigger <= 3'h0;
        end else begin
            {comparator0_trigger, external_trigger_pin, timer_trigger} <= cmd[6:4];
            timer_output_trigger_enable <= cmd.timer_ote;
            pwm_gen_trigger <= cmd.pwm;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tb_ats_trigger_select.sv
// self-checking bench for the sequencer trigger select block
`timescale 1ns/1ps
`default_nettype none

module tb_ats_trigger_select
    import ats_pkg::*;
;
    typedef struct packed {
        logic [3:0] code;
        ats_src_t stim;
        logic proc;
        logic exp;
    } ats_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:1] proc = 2'h0;
    ats_src_t cmd = 7'h00;
    logic comp, pin, tmr, ote, s2, s1;
    logic [2:0] pwm;
    logic [31:0] q;
    logic e;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    // code, producer command, processor request, expected start of both sequencers
    ats_row_t rows [14] = '{'{4'h0, 7'h00, 1'b1, 1'b1}, '{4'h0, 7'h40, 1'b0, 1'b0},
        '{4'h1, 7'h40, 1'b0, 1'b1}, '{4'h1, 7'h01, 1'b1, 1'b0}, '{4'h2, 7'h5F, 1'b1, 1'b0},
        '{4'h3, 7'h5F, 1'b1, 1'b0}, '{4'h5, 7'h18, 1'b0, 1'b1}, '{4'h5, 7'h10, 1'b0, 1'b0},
        '{4'h5, 7'h08, 1'b0, 1'b0}, '{4'h6, 7'h01, 1'b0, 1'b1}, '{4'h6, 7'h06, 1'b1, 1'b0},
        '{4'h7, 7'h02, 1'b0, 1'b1}, '{4'h8, 7'h04, 1'b0, 1'b1}, '{4'hF, 7'h00, 1'b0, 1'b1}};

    ats_trigger_select ats_trigger_select_i(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .proc_sample_req(proc),
        .comparator0_trigger(comp), .external_trigger_pin(pin), .timer_trigger(tmr),
        .timer_output_trigger_enable(ote), .pwm_gen_trigger(pwm), .seq2_start(s2),
        .seq1_start(s1));
    ats_src_model ats_src_model_i(.pclk(pclk), .presetn(presetn), .cmd(cmd),
        .comparator0_trigger(comp), .external_trigger_pin(pin), .timer_trigger(tmr),
        .timer_output_trigger_enable(ote), .pwm_gen_trigger(pwm));

    // ****************************************************************
    // helpers
    // ****************************************************************
    initial begin
        forever #10 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one apb transfer; an idle cycle follows so no strobe is assigned twice in one step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // producers fire one edge after cmd, so the request is delayed to line up with them
    task fire(input ats_src_t s, input logic p);
        cmd <= s;
        @(posedge pclk);
        cmd <= 7'h00;
        proc <= {p, p};
        @(posedge pclk);
        proc <= 2'h0;
        #1;
    endtask
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ATS_TRIGSEL_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b1, ATS_TRIGSEL_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, ATS_TRIGSEL_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0FF0);
        apb(1'b1, ATS_TRIGSEL_OFFSET, 32'h0000_0650);
        // both sequencers ran continuously above; clear both status bits so the pwm start stands alone
        apb(1'b1, ATS_STATUS_OFFSET, 32'h0000_0003);
        fire(7'h01, 1'b0);
        chk({30'h0000_0000, s2, s1}, 32'h0000_0002);
        @(posedge pclk);
        apb(1'b0, ATS_STATUS_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0002);
        apb(1'b1, ATS_STATUS_OFFSET, 32'h0000_0002);
        apb(1'b0, ATS_STATUS_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        foreach (rows[i]) begin
            apb(1'b1, ATS_TRIGSEL_OFFSET, {20'h0_0000, rows[i].code, rows[i].code, 4'h0});
            fire(rows[i].stim, rows[i].proc);
            chk({30'h0000_0000, s2, s1}, {30'h0000_0000, rows[i].exp, rows[i].exp});
            @(posedge pclk);
        end
        // every reserved code above the pwm range, with every producer except the pin firing
        for (int c = 9; c < 15; c++) begin
            apb(1'b1, ATS_TRIGSEL_OFFSET, {20'h0_0000, c[3:0], c[3:0], 4'h0});
            fire(7'h5F, 1'b1);
            chk({30'h0000_0000, s2, s1}, 32'h0000_0000);
            @(posedge pclk);
        end
        // pin edge: sync plus edge detect gives a start four edges after the command
        apb(1'b1, ATS_TRIGSEL_OFFSET, 32'h0000_0440);
        cmd <= 7'h20;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            #1;
        end while (s2 !== 1'b1 && n < 10);
        chk(n, 4);
        @(posedge pclk);
        #1;
        chk({30'h0000_0000, s2, s1}, 32'h0000_0000);
        @(posedge pclk);
        cmd <= 7'h00;
        // unmapped accesses error, read zero and leave the select word alone
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        chk(e, 1'b1);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk(e, 1'b1);
        chk(q, 32'h0000_0000);
        apb(1'b0, ATS_TRIGSEL_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0440);
        apb(1'b1, ATS_TRIGSEL_OFFSET, 32'h0000_0FF0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk({30'h0000_0000, s2, s1}, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ATS_TRIGSEL_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, ATS_STATUS_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wrap_up();
    end
endmodule

`default_nettype wire
